// ---- core/ssifs_top.sv ----
// Implementation choices: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps
// Overview of operation
// - sync length code: 00 word both, 01 tx bit, 10 bit both, 11 rx bit
// - shared clocking ignores the low sync length bit
// - early word sync leads first data bit by one bit clock
// - polarity bit set means low level marks frame start
// - status is eight read-only bits, upper bus bits zero
// - control pins caught on first bit, shown at word transfer
// - input flags need serial pin function, shared clocking, input direction
// - transmit first-slot flag set in slot zero, cleared otherwise
// - network word written in slot zero goes out in slot one
// - normal mode first-slot flags read one
// - receive first-slot flag tells a sync came during the word
// - slot with no new data sets underrun and resends old word
// - one slot per frame normally, up to 32 in network mode
// - underrun request when enabled; cleared by status read then write
// - overrun set when a word completes while receive data full
// - overrun request when enabled; cleared by status read then data read
// - empty set on shift load or null slot
// - empty cleared by data or null write, set by resets
// - full set on transfer, cleared by data read, with request
// - every reset clears input, slot, error and full flags
// - receive shifter starts on active sync, then runs for the word, lsb or msb first
// - transfer after 8, 12 or 16 bit clocks
// - shared clocking uses transmit clock and sync for both
// - received word left aligned, low bits zero
module ssifs_top #(
  parameter int DW = 16
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        xmit_clk_pin,
  input  wire logic        xmit_sync_pin,
  input  wire logic        rcv_clk_pin,
  input  wire logic        rcv_sync_pin,
  input  wire logic        serial_in_pin,
  input  wire logic        ctrl_pin_zero,
  input  wire logic        ctrl_pin_one,
  input  wire logic        stop_req,
  output logic             serial_out,
  output logic             serial_out_en_n,
  output logic             xmit_error_irq,
  output logic             rcv_error_irq,
  output logic             xmit_data_irq,
  output logic             rcv_data_irq
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] wlen(input logic [1:0] sel);
    wlen = (sel == 2'h0) ? ssifs_pkg::WLEN_8 :
           (sel == 2'h1) ? ssifs_pkg::WLEN_12 : ssifs_pkg::WLEN_16;
  endfunction
  // one-bit sync decode per direction
  function automatic logic one_bit(input logic tx, input logic hi, input logic lo);
    one_bit = tx ? (hi ^ lo) : hi;
  endfunction
  // left-aligned word to or from shifter order
  function automatic logic [DW-1:0] align(input logic [DW-1:0] v, input logic [4:0] n,
                                          input logic lsb, input logic to_left);
    logic [4:0] sh;
    sh = ssifs_pkg::WLEN_16 - n;
    if (lsb == to_left) begin
      align = v;
    end else if (to_left) begin
      align = v << sh;
    end else begin
      align = v >> sh;
    end
  endfunction
  // ---------------------------------------------------------------
  // pin synchronisers and edges
  // ---------------------------------------------------------------
  logic [7:0] pin_s1_r, pin_s2_r, pin_d_r;
  always_ff @(posedge aclk) begin
    pin_s1_r <= {stop_req, ctrl_pin_one, ctrl_pin_zero, serial_in_pin,
                 rcv_sync_pin, rcv_clk_pin, xmit_sync_pin, xmit_clk_pin};
    pin_s2_r <= pin_s1_r;
    pin_d_r  <= pin_s2_r;
  end
  ssifs_pkg::ssifs_ctrl_type ctrl_r;
  ssifs_pkg::ssifs_status_type st_r;
  logic [4:0]  slots_r;
  wire         ccs       = ctrl_r.common_clocking_sel;
  wire         net       = ctrl_r.network_mode;
  wire         lsb       = ctrl_r.lsb_first_sel;
  wire  [4:0]  len       = wlen(ctrl_r.word_len_sel);
  wire         fsl_lo    = ctrl_r.frame_sync_length_sel_lo & ~ccs;
  wire         tx_one    = one_bit(1'b1, ctrl_r.frame_sync_length_sel_hi, fsl_lo);
  wire         rx_one    = one_bit(1'b0, ctrl_r.frame_sync_length_sel_hi, fsl_lo);
  wire         rx_clk    = ccs ? pin_s2_r[0] : pin_s2_r[2];
  wire         rx_clk_d  = ccs ? pin_d_r[0] : pin_d_r[2];
  wire         rx_fs_raw = ccs ? pin_s2_r[1] : pin_s2_r[3];
  wire         tx_fs     = pin_s2_r[1] ^ ctrl_r.sync_polarity;
  wire         rx_fs     = rx_fs_raw ^ ctrl_r.sync_polarity;
  wire         tx_edge   = pin_s2_r[0] & ~pin_d_r[0];
  wire         rx_edge   = ~rx_clk & rx_clk_d;
  wire         loc_rst   = ctrl_r.soft_reset | pin_s2_r[7];
  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  logic        aw_have_r, w_have_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  wire         wr_go   = aw_have_r & w_have_r & ~s_axi_bvalid;
  wire         wr_ctrl = wr_go & (aw_addr_r == ssifs_pkg::ADDR_CTRL);
  wire         wr_tx   = wr_go & (aw_addr_r == ssifs_pkg::ADDR_TXDATA);
  wire         wr_null = wr_go & (aw_addr_r == ssifs_pkg::ADDR_NULL);
  wire         wr_slot = wr_go & (aw_addr_r == ssifs_pkg::ADDR_SLOTS);
  wire         wr_ok   = wr_ctrl | wr_tx | wr_null | wr_slot;
  wire         rd_go   = s_axi_arvalid & s_axi_arready;
  wire         rd_st   = rd_go & (s_axi_araddr == ssifs_pkg::ADDR_STATUS);
  wire         rd_rx   = rd_go & (s_axi_araddr == ssifs_pkg::ADDR_RXDATA);
  wire         rd_ok   = rd_st | rd_rx | (s_axi_araddr == ssifs_pkg::ADDR_CTRL)
                         | (s_axi_araddr == ssifs_pkg::ADDR_SLOTS);
  logic [DW-1:0] rx_data_r, tx_data_r;
  wire         if0_en = ctrl_r.pc_zero & ccs & ~ctrl_r.ctrl_pin_zero_dir;
  wire         if1_en = ctrl_r.pc_one & ccs & ~ctrl_r.ctrl_pin_one_dir;
  ssifs_pkg::ssifs_status_type st_view;
  always_comb begin
    st_view = st_r;
    st_view.input_flag_zero = st_r.input_flag_zero & if0_en;
    st_view.input_flag_one  = st_r.input_flag_one & if1_en;
  end
  wire [31:0] rd_mux =
    (s_axi_araddr == ssifs_pkg::ADDR_CTRL)   ? 32'(ctrl_r) :
    (s_axi_araddr == ssifs_pkg::ADDR_STATUS) ? {24'h00_0000, st_view} :
    (s_axi_araddr == ssifs_pkg::ADDR_RXDATA) ? 32'(rx_data_r) :
    (s_axi_araddr == ssifs_pkg::ADDR_SLOTS)  ? {27'h000_0000, slots_r} : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= ssifs_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= ssifs_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_have_r <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
      end else if (wr_go) begin
        w_have_r <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? ssifs_pkg::RESP_OKAY : ssifs_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? ssifs_pkg::RESP_OKAY : ssifs_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = ~aw_have_r;
  assign s_axi_wready  = ~w_have_r;
  assign s_axi_arready = ~s_axi_rvalid;
  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= ssifs_pkg::CTRL_RST;
      slots_r   <= ssifs_pkg::SLOTS_RST;
      tx_data_r <= '0;
    end else begin
      ctrl_r.soft_reset <= 1'b0;
      if (wr_ctrl) begin
        ctrl_r <= w_data_r & ~32'h7C00_0F70 | (32'h1 << ssifs_pkg::SOFT_RST_BIT) & w_data_r;
      end
      if (wr_slot) begin
        slots_r <= w_data_r[4:0];
      end
      if (wr_tx) begin
        tx_data_r <= w_data_r[DW-1:0];
      end
    end
  end
  // ---------------------------------------------------------------
  // receive path
  // ---------------------------------------------------------------
  logic          rx_busy_r, rx_arm_r, rx_seen_r, if0_cap_r, if1_cap_r;
  logic [4:0]    rx_cnt_r;
  logic [DW-1:0] rx_sr_r;
  wire           early_w  = ctrl_r.sync_early & ~rx_one;
  wire           rx_idle  = ~rx_busy_r & ~rx_arm_r;
  // early word sync arms, data next bit
  wire           rx_arm   = rx_edge & rx_idle & rx_fs & early_w;
  wire           rx_start = rx_arm_r | (rx_idle & rx_fs & ~early_w);
  wire           rx_take  = rx_edge & ctrl_r.rcv_enable & (rx_start | rx_busy_r);
  wire [DW-1:0]  rx_base  = (rx_cnt_r == 5'h00) ? '0 : rx_sr_r;
  wire [DW-1:0]  rx_sr_nxt = lsb ? {pin_s2_r[4], rx_base[DW-1:1]}
                                 : {rx_base[DW-2:0], pin_s2_r[4]};
  wire [4:0]     rx_cnt_nxt = rx_cnt_r + 5'h01;
  wire           rx_done  = rx_take & (rx_cnt_nxt == len);
  wire           rx_seen_nxt = ((rx_cnt_r == 5'h00) ? 1'b0 : rx_seen_r) | rx_fs | rx_arm_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || loc_rst) begin
      rx_busy_r <= 1'b0;
      rx_arm_r  <= 1'b0;
      rx_seen_r <= 1'b0;
      rx_cnt_r  <= 5'h00;
      rx_sr_r   <= '0;
      if0_cap_r <= 1'b0;
      if1_cap_r <= 1'b0;
    end else if (rx_take) begin
      rx_arm_r  <= 1'b0;
      rx_sr_r   <= rx_sr_nxt;
      rx_seen_r <= rx_seen_nxt;
      if (rx_cnt_r == 5'h00) begin
        if0_cap_r <= pin_s2_r[5];
        if1_cap_r <= pin_s2_r[6];
      end
      rx_cnt_r  <= rx_done ? 5'h00 : rx_cnt_nxt;
      rx_busy_r <= ~rx_done | net;
    end else if (rx_arm) begin
      rx_arm_r <= 1'b1;
    end
  end
  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic          tx_busy_r, tx_arm_r, tx_fs_d_r, null_pend_r;
  logic [4:0]    tx_cnt_r, slot_r;
  logic [DW-1:0] tx_sh_r;
  wire           tx_early = ctrl_r.sync_early & ~tx_one;
  wire           tx_new   = tx_fs & ~tx_fs_d_r;
  wire           tx_frame = tx_arm_r | (tx_new & ~tx_early);
  wire           tx_wend  = tx_busy_r & (tx_cnt_r == len - 5'h01);
  wire           tx_more  = net & (slot_r != slots_r);
  wire           tx_slot  = ctrl_r.xmit_on & tx_edge & (tx_frame | (tx_wend & tx_more));
  wire           tx_under = tx_slot & st_r.xmit_empty_flag;
  wire           tx_null  = tx_slot & ~st_r.xmit_empty_flag & null_pend_r;
  wire [DW-1:0]  tx_load  = align(tx_data_r, len, lsb, 1'b0);
  always_ff @(posedge aclk) begin
    if (!aresetn || loc_rst) begin
      tx_busy_r  <= 1'b0;
      tx_arm_r   <= 1'b0;
      tx_fs_d_r  <= 1'b0;
      tx_cnt_r   <= 5'h00;
      slot_r     <= 5'h00;
      tx_sh_r    <= '0;
      serial_out <= 1'b0;
      serial_out_en_n <= 1'b1;
    end else if (tx_edge) begin
      tx_fs_d_r <= tx_fs;
      tx_arm_r  <= ctrl_r.xmit_on & tx_new & tx_early;
      if (tx_slot) begin
        slot_r   <= tx_frame ? 5'h00 : slot_r + 5'h01;
        tx_busy_r <= 1'b1;
        tx_cnt_r <= 5'h00;
        tx_sh_r  <= lsb ? tx_load >> 1 : tx_load << 1;
        serial_out <= lsb ? tx_load[0] : tx_load[DW-1];
        serial_out_en_n <= tx_null;
      end else if (tx_busy_r) begin
        tx_cnt_r <= tx_cnt_r + 5'h01;
        tx_sh_r  <= lsb ? tx_sh_r >> 1 : tx_sh_r << 1;
        serial_out <= lsb ? tx_sh_r[0] : tx_sh_r[DW-1];
        if (tx_wend) begin
          tx_busy_r <= 1'b0;
          serial_out_en_n <= 1'b1;
        end
      end
    end else if (!tx_fs) begin
      // inactive sync rearms frame start while the bit clock stands still
      tx_fs_d_r <= 1'b0;
    end
  end
  // ---------------------------------------------------------------
  // status flags
  // ---------------------------------------------------------------
  logic tue_seen_r, roe_seen_r;
  wire  rx_clr = rd_rx;
  always_ff @(posedge aclk) begin
    if (!aresetn || loc_rst) begin
      st_r <= '0;
      st_r.xmit_empty_flag <= 1'b1;
      null_pend_r <= 1'b0;
      tue_seen_r  <= 1'b0;
      roe_seen_r  <= 1'b0;
      rx_data_r   <= '0;
    end else begin
      if (rd_st) begin
        tue_seen_r <= st_r.xmit_underrun_flag;
        roe_seen_r <= st_r.rcv_overrun_flag;
      end
      if (wr_tx | wr_null) begin
        st_r.xmit_empty_flag <= 1'b0;
        null_pend_r <= wr_null;
      end
      if ((wr_tx | wr_null) & tue_seen_r) begin
        st_r.xmit_underrun_flag <= 1'b0;
        tue_seen_r <= 1'b0;
      end
      if (rx_clr) begin
        st_r.rcv_full_flag <= 1'b0;
      end
      if (rx_clr & roe_seen_r) begin
        st_r.rcv_overrun_flag <= 1'b0;
        roe_seen_r <= 1'b0;
      end
      if (tx_slot) begin
        st_r.xmit_empty_flag <= 1'b1;
        null_pend_r <= 1'b0;
        st_r.xmit_first_slot_flag <= tx_frame | ~net;
      end
      if (tx_under) begin
        st_r.xmit_underrun_flag <= 1'b1;
      end
      if (rx_done) begin
        rx_data_r <= align(rx_sr_nxt, len, lsb, 1'b1);
        st_r.rcv_full_flag <= 1'b1;
        if (st_r.rcv_full_flag & ~rx_clr) begin
          st_r.rcv_overrun_flag <= 1'b1;
        end
        st_r.rcv_first_slot_flag <= rx_seen_nxt | ~net;
        st_r.input_flag_zero <= if0_cap_r;
        st_r.input_flag_one  <= if1_cap_r;
      end
    end
  end
  // ---------------------------------------------------------------
  // request outputs
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xmit_error_irq <= 1'b0;
      rcv_error_irq  <= 1'b0;
      xmit_data_irq  <= 1'b0;
      rcv_data_irq   <= 1'b0;
    end else begin
      xmit_error_irq <= ctrl_r.xmit_error_irq_en & st_r.xmit_underrun_flag;
      rcv_error_irq  <= ctrl_r.rcv_error_irq_en & st_r.rcv_overrun_flag;
      xmit_data_irq  <= ctrl_r.xmit_data_irq_en & st_r.xmit_empty_flag;
      rcv_data_irq   <= ctrl_r.rcv_data_irq_en & st_r.rcv_full_flag;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rx_full_set: assert property (rx_done |=> st_r.rcv_full_flag)
    else $error("full not set after transfer");
  a_rx_overrun: assert property (rx_done & st_r.rcv_full_flag & ~rx_clr & ~loc_rst
    |=> st_r.rcv_overrun_flag)
    else $error("overrun missed");
  a_tx_underrun: assert property (tx_under & ~loc_rst |=> st_r.xmit_underrun_flag)
    else $error("underrun missed");
  a_tx_empty_clr: assert property (wr_tx & ~tx_slot & ~loc_rst
    |=> !st_r.xmit_empty_flag)
    else $error("empty not cleared");
  a_status_high: assert property (s_axi_rvalid & $past(rd_st)
    |-> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("status upper bits set");
  a_if_gate: assert property (rd_st & ~if0_en |=> s_axi_rdata[0] == 1'b0)
    else $error("input flag not gated");
  a_rx_low_zero: assert property (rx_done & (len == ssifs_pkg::WLEN_8) & ~loc_rst
    |=> rx_data_r[7:0] == 8'h00)
    else $error("low bits not zero");
  a_rst_flags: assert property (loc_rst |=> st_r.rcv_full_flag == 1'b0
    && st_r.xmit_empty_flag)
    else $error("reset flags wrong");
  a_norm_first: assert property (tx_slot & ~net & ~loc_rst
    |=> st_r.xmit_first_slot_flag)
    else $error("first slot flag low");
  c_rx_word: cover property (rx_done);
  c_tx_under: cover property (tx_under);
  c_tx_null: cover property (tx_null);
endmodule

// ---- core/ssifs_pkg.sv ----
package ssifs_pkg;
  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RXDATA = 8'h08;
  localparam logic [7:0] ADDR_TXDATA = 8'h0C;
  localparam logic [7:0] ADDR_NULL   = 8'h10;
  localparam logic [7:0] ADDR_SLOTS  = 8'h14;
  // ---------------------------------------------------------------
  // reset values and responses
  // ---------------------------------------------------------------
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [4:0]  SLOTS_RST  = 5'h00;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam int          SOFT_RST_BIT = 31;
  // ---------------------------------------------------------------
  // word lengths
  // ---------------------------------------------------------------
  localparam logic [4:0] WLEN_8  = 5'h08;
  localparam logic [4:0] WLEN_12 = 5'h0C;
  localparam logic [4:0] WLEN_16 = 5'h10;
  // ---------------------------------------------------------------
  // control register layout, bit 31 downward
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       soft_reset;
    logic [4:0] rsvd_hi;
    logic       pc_one;
    logic       pc_zero;
    logic       rcv_data_irq_en;
    logic       xmit_data_irq_en;
    logic       rcv_error_irq_en;
    logic       xmit_error_irq_en;
    logic       rcv_enable;
    logic       xmit_on;
    logic [1:0] word_len_sel;
    logic       sync_polarity;
    logic       sync_early;
    logic       frame_sync_length_sel_hi;
    logic       frame_sync_length_sel_lo;
    logic [3:0] rsvd_mid;
    logic       lsb_first_sel;
    logic [2:0] rsvd_lo;
    logic       ctrl_pin_one_dir;
    logic       ctrl_pin_zero_dir;
    logic       network_mode;
    logic       common_clocking_sel;
  } ssifs_ctrl_type;
  // ---------------------------------------------------------------
  // status register layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic rcv_full_flag;
    logic xmit_empty_flag;
    logic rcv_overrun_flag;
    logic xmit_underrun_flag;
    logic rcv_first_slot_flag;
    logic xmit_first_slot_flag;
    logic input_flag_one;
    logic input_flag_zero;
  } ssifs_status_type;
endpackage

// ---- dv/ssifs_codec.sv ----
`timescale 1ns/10ps
// --------------------------------------------
// far-side codec: bit clock, sync, data
// --------------------------------------------
module ssifs_codec (
  input  wire logic        go,
  input  wire logic [15:0] word,
  output logic             bclk,
  output logic             fsync,
  output logic             sdata
);
  initial begin
    bclk = 1'b0;
    fsync = 1'b0;
    sdata = 1'b0;
  end
  // clock stands still low between frames
  always @(posedge go) begin
    for (int i = 15; i >= 8; i--) begin
      bclk = 1'b1;
      fsync = 1'b1;
      sdata = word[i];
      #80 bclk = 1'b0;
      #80;
    end
    fsync = 1'b0;
    sdata = ~sdata;
  end
endmodule

// ---- dv/serial_port_framesync_status_test.sv ----
`timescale 1ns/10ps
module serial_port_framesync_status_test;
  // --------------------------------------------
  // signals, rows and design
  // --------------------------------------------
  logic        aclk, aresetn, go, p0, p1, bclk, fsync, sdata;
  logic [15:0] word;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        rcv_error_irq, rcv_data_irq;
  logic        serial_out, serial_out_en_n, xmit_error_irq, xmit_data_irq;
  int          error_cnt, checks;
  logic [7:0]  row_a [4] = '{ssifs_pkg::ADDR_STATUS, ssifs_pkg::ADDR_CTRL,
                             ssifs_pkg::ADDR_SLOTS, 8'h18};
  logic [31:0] row_d [4] = '{32'h0000_0040, ssifs_pkg::CTRL_RST, 32'h0, 32'h0};
  logic [1:0]  row_r [4] = '{ssifs_pkg::RESP_OKAY, ssifs_pkg::RESP_OKAY,
                             ssifs_pkg::RESP_OKAY, ssifs_pkg::RESP_SLVERR};
  ssifs_top uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .xmit_clk_pin(bclk), .xmit_sync_pin(fsync),
    .rcv_clk_pin(1'b0), .rcv_sync_pin(1'b0), .serial_in_pin(sdata), .ctrl_pin_zero(p0),
    .ctrl_pin_one(p1), .stop_req(1'b0), .serial_out, .serial_out_en_n,
    .xmit_error_irq, .rcv_error_irq, .xmit_data_irq, .rcv_data_irq
  );
  ssifs_codec codec (.go, .word, .bclk, .fsync, .sdata);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, 32'h0);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd & m, e);
  endtask
  task automatic send(input logic [15:0] w, input logic a, input logic b);
    @(posedge aclk);
    word <= w;
    p0 <= a;
    p1 <= b;
    go <= 1'b1;
    repeat (80) @(posedge aclk);
    go <= 1'b0;
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // --------------------------------------------
  // clock, watchdog and sequence
  // --------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    print_verdict();
  end
  initial begin
    {aresetn, go, p0, p1, word, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rc(row_a[i], row_d[i], 32'hFFFF_FFFF);
      chk({30'h0, rr}, {30'h0, row_r[i]});
    end
    wr(ssifs_pkg::ADDR_CTRL, 32'h03A8_0001);
    send(16'hA500, 1'b1, 1'b0);
    chk({31'h0, rcv_data_irq}, 32'h1);
    rc(ssifs_pkg::ADDR_STATUS, 32'hC9, 32'hFFFF_FFFB);
    send(16'h3C00, 1'b0, 1'b1);
    chk({31'h0, rcv_error_irq}, 32'h1);
    rc(ssifs_pkg::ADDR_STATUS, 32'hEA, 32'hFFFF_FFFB);
    rc(ssifs_pkg::ADDR_RXDATA, 32'h3C00, 32'hFFFF_FFFF);
    rc(ssifs_pkg::ADDR_STATUS, 32'h4A, 32'hFFFF_FFFB);
    wr(ssifs_pkg::ADDR_CTRL, 32'h03A8_0085);
    send(16'hC100, 1'b1, 1'b1);
    rc(ssifs_pkg::ADDR_STATUS, 32'hCA, 32'hFFFF_FFFB);
    rc(ssifs_pkg::ADDR_RXDATA, 32'h8300, 32'hFFFF_FFFF);
    wr(ssifs_pkg::ADDR_CTRL, 32'h8000_0000);
    rc(ssifs_pkg::ADDR_STATUS, 32'h40, 32'hFFFF_FFFF);
    wr(ssifs_pkg::ADDR_CTRL, 32'h0054_0001);
    send(16'h0000, 1'b0, 1'b0);
    chk({30'h0, xmit_error_irq, xmit_data_irq}, 32'h3);
    rc(ssifs_pkg::ADDR_STATUS, 32'h54, 32'hFFFF_FFFF);
    wr(ssifs_pkg::ADDR_TXDATA, 32'h0000_8100);
    rc(ssifs_pkg::ADDR_STATUS, 32'h04, 32'hFFFF_FFFF);
    chk({30'h0, xmit_error_irq, xmit_data_irq}, 32'h0);
    send(16'h0000, 1'b0, 1'b0);
    chk({30'h0, serial_out_en_n, serial_out}, 32'h1);
    chk({31'h0, xmit_data_irq}, 32'h1);
    rc(ssifs_pkg::ADDR_STATUS, 32'h44, 32'hFFFF_FFFF);
    print_verdict();
  end
endmodule
